/* dbp_pkg.sv */
package dbp_pkg;

  // ----------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------
  localparam int PIN_W     = 12;
  localparam int PIN_SYNC  = 11;
  localparam int PIN_SCLK  = 10;
  localparam int PIN_DIN   = 9;
  localparam int PIN_WR    = 8;
  localparam int PIN_STRAP = 7;
  localparam int PIN_OFS   = 6;
  localparam int PIN_CAL   = 5;
  localparam int PIN_ADDR  = 0;
  localparam int ADDR_W    = 5;
  // idle levels: frame sync and write strobe high, all else low
  localparam logic [PIN_W-1:0] PIN_RST = 12'h900;

  // ----------------------------------------
  // frame and storage sizes
  // ----------------------------------------
  localparam int CODE_W     = 14;
  localparam int HDR_W      = 10;
  localparam int SH_W       = 24;
  localparam int CHAN_N     = 32;
  localparam int MEM_N      = 33;
  localparam int SEL_W      = 6;
  localparam logic [SEL_W-1:0] OFFSET_IDX = 6'h20;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] HDR_CNT = 5'h0A;
  localparam logic [CNT_W-1:0] DAC_CNT = 5'h18;
  localparam logic [CNT_W-1:0] RD_CNT  = 5'h0E;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_TRACK = 2'h0,
    MODE_LOAD  = 2'h1,
    MODE_ACQRD = 2'h2,
    MODE_RD    = 2'h3
  } dbp_mode_t;

  // addressing field, first bit on the wire at the top
  typedef struct packed {
    dbp_mode_t         mode;
    logic              all;
    logic              offset;
    logic [ADDR_W-1:0] chan;
    logic              spare;
  } dbp_hdr_t;

  // command handed to the analog core
  typedef struct packed {
    logic              all;
    logic              offset;
    logic [ADDR_W-1:0] chan;
    logic [CODE_W-1:0] code;
  } dbp_cmd_t;

  typedef enum logic [1:0] {
    SP_IDLE,
    SP_SHIFT,
    SP_READ
  } dbp_state_t;

endpackage : dbp_pkg

/* dbp_port.sv */
// Summary of operation
// - readback mode shifts addressed register, no acquisition
// - strap high enables serial, disables parallel
// - bit launched on rise, host samples fall
// - broadcast loads or acquires all 32 channels
// - offset select addresses the offset channel
// - five address bits pick one of 32
// - code field written only in load mode
// - continuous or gated serial clock both work
// - frame sync fall clears the clock counter
// - ignore sync edges and surplus clocks correctly
// - output enabled first rise, off 14th fall
// - input sampled on each falling clock edge
// - input line ignored during readback
// - nothing shifts before a frame sync fall
// - strap low enables track-only parallel port
// - parallel pins captured on write strobe rise
// - chip select shares the frame sync pin
// - parallel offset select overrides address pins
// - parallel broadcast makes all channels acquire
// - words travel most significant bit first
// - first two bits select the mode
// - load frame is 10 plus 14 bits
// - track frame is 10 bits
//
// Strobed register access and the placing of the registers are this design's own decisions.
module dbp_port
  import dbp_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // shared pins
  input  wire logic              sync_cs_n,
  input  wire logic              port_select_strap,
  // serial link
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  // parallel port
  input  wire logic              wr_n,
  input  wire logic [ADDR_W-1:0] channel_address,
  input  wire logic              offset_sel,
  input  wire logic              cal,
  // analog core side
  output logic                   acq_pulse,
  output logic                   load_pulse,
  output dbp_cmd_t               cmd
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1;
  logic [PIN_W-1:0] s2;
  logic [PIN_W-1:0] s3;
  logic [PIN_W-1:0] pin_f;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] next_pin_f;

  assign pin_raw = {sync_cs_n, sclk, din, wr_n, port_select_strap,
                    offset_sel, cal, channel_address};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      // a change counts once stages two and three agree
      always_comb begin
        next_pin_f[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pin_f[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= PIN_RST;
      s2    <= PIN_RST;
      s3    <= PIN_RST;
      pin_f <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      s1    <= pin_raw;
      s2    <= s1;
      s3    <= s2;
      pin_f <= next_pin_f;
      pin_q <= pin_f;
    end
  end

  logic ser_en;
  logic sync_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_rise;

  assign sync_fall = pin_q[PIN_SYNC] & ~pin_f[PIN_SYNC];
  assign sclk_rise = ~pin_q[PIN_SCLK] & pin_f[PIN_SCLK];
  assign sclk_fall = pin_q[PIN_SCLK] & ~pin_f[PIN_SCLK];
  assign wr_rise   = ~pin_q[PIN_WR] & pin_f[PIN_WR];
  assign ser_en    = pin_f[PIN_STRAP];

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  logic [CODE_W-1:0] code_mem [MEM_N];
  logic [SEL_W-1:0]  wr_sel;

  assign wr_sel = cmd.offset ? OFFSET_IDX : {1'b0, cmd.chan};

  generate
    for (gi = 0; gi < MEM_N; gi++) begin : g_mem
      logic hit;
      assign hit = cmd.all ? (gi < CHAN_N) : (wr_sel == SEL_W'(gi));
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          code_mem[gi] <= '0;
        end else if (load_pulse && hit) begin
          code_mem[gi] <= cmd.code;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // serial and parallel command engine
  // ----------------------------------------
  dbp_state_t        state;
  dbp_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [SH_W-1:0]   shreg;
  logic [SH_W-1:0]   next_shreg;
  logic [SH_W-1:0]   sh_in;
  logic [CNT_W-1:0]  cnt_inc;
  logic [CODE_W-1:0] out_sh;
  logic [CODE_W-1:0] next_out_sh;
  logic              rd_pend;
  logic              next_rd_pend;
  logic [SEL_W-1:0]  rd_sel;
  logic [SEL_W-1:0]  next_rd_sel;
  logic              next_dout;
  logic              next_dout_oe;
  logic              next_acq_pulse;
  logic              next_load_pulse;
  dbp_cmd_t          next_cmd;
  dbp_hdr_t          hdr_now;
  dbp_hdr_t          hdr_ld;

  assign sh_in   = {shreg[SH_W-2:0], pin_f[PIN_DIN]};
  assign cnt_inc = cnt + 5'h01;
  assign hdr_now = dbp_hdr_t'(sh_in[HDR_W-1:0]);
  assign hdr_ld  = dbp_hdr_t'(sh_in[SH_W-1:CODE_W]);

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_shreg      = shreg;
    next_out_sh     = out_sh;
    next_rd_pend    = rd_pend;
    next_rd_sel     = rd_sel;
    next_dout       = dout;
    next_dout_oe    = dout_oe;
    next_acq_pulse  = 1'b0;
    next_load_pulse = 1'b0;
    next_cmd        = cmd;
    if (!ser_en) begin
      next_state   = SP_IDLE;
      next_dout_oe = 1'b0;
      next_rd_pend = 1'b0;
      if (wr_rise && !pin_f[PIN_SYNC]) begin
        next_acq_pulse = 1'b1;
        next_cmd.all    = pin_f[PIN_CAL];
        next_cmd.offset = pin_f[PIN_OFS];
        next_cmd.chan   = pin_f[PIN_OFS] ? '0 : pin_f[PIN_ADDR +: ADDR_W];
        next_cmd.code   = '0;
      end
    end else begin
      unique case (state)
        SP_IDLE: begin
          if (sync_fall) begin
            next_cnt    = '0;
            next_out_sh = code_mem[rd_sel];
            next_state  = rd_pend ? SP_READ : SP_SHIFT;
          end
        end
        SP_SHIFT: begin
          if (sclk_fall) begin
            next_shreg = sh_in;
            next_cnt   = cnt_inc;
            if (cnt_inc == HDR_CNT) begin
              next_cmd.all    = hdr_now.all;
              next_cmd.offset = hdr_now.offset;
              next_cmd.chan   = hdr_now.chan;
              next_cmd.code   = '0;
              next_rd_sel     = hdr_now.offset ? OFFSET_IDX
                                               : {1'b0, hdr_now.chan};
              if (hdr_now.mode != MODE_LOAD) begin
                next_state = SP_IDLE;
              end
              if (hdr_now.mode == MODE_TRACK || hdr_now.mode == MODE_ACQRD) begin
                next_acq_pulse = 1'b1;
              end
              if (hdr_now.mode == MODE_ACQRD || hdr_now.mode == MODE_RD) begin
                next_rd_pend = 1'b1;
              end
            end else if (cnt_inc == DAC_CNT) begin
              // code stored in load mode only
              next_cmd.all    = hdr_ld.all;
              next_cmd.offset = hdr_ld.offset;
              next_cmd.chan   = hdr_ld.chan;
              next_cmd.code   = sh_in[CODE_W-1:0];
              next_load_pulse = 1'b1;
              next_state      = SP_IDLE;
            end
          end
        end
        SP_READ: begin
          if (sclk_rise) begin
            next_dout    = out_sh[CODE_W-1];
            next_out_sh  = {out_sh[CODE_W-2:0], 1'b0};
            next_dout_oe = 1'b1;
          end else if (sclk_fall) begin
            next_cnt = cnt_inc;
            if (cnt_inc == RD_CNT) begin
              next_dout_oe = 1'b0;
              next_rd_pend = 1'b0;
              next_state   = SP_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= SP_IDLE;
      cnt        <= '0;
      shreg      <= '0;
      out_sh     <= '0;
      rd_pend    <= 1'b0;
      rd_sel     <= '0;
      dout       <= 1'b0;
      dout_oe    <= 1'b0;
      acq_pulse  <= 1'b0;
      load_pulse <= 1'b0;
      cmd        <= '0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shreg      <= next_shreg;
      out_sh     <= next_out_sh;
      rd_pend    <= next_rd_pend;
      rd_sel     <= next_rd_sel;
      dout       <= next_dout;
      dout_oe    <= next_dout_oe;
      acq_pulse  <= next_acq_pulse;
      load_pulse <= next_load_pulse;
      cmd        <= next_cmd;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_par_write;
    !ser_en && wr_rise && !pin_f[PIN_SYNC];
  endsequence

  sequence s_rd_start;
    ser_en && state == SP_IDLE && sync_fall && rd_pend;
  endsequence

  sequence s_last_fall;
    ser_en && state == SP_READ && sclk_fall && cnt == RD_CNT - 5'h01;
  endsequence

  par_off_a: assert property (!ser_en |=> state == SP_IDLE && !dout_oe)
    else $error("serial logic active with strap low");

  idle_wait_a: assert property (ser_en && state == SP_IDLE && !sync_fall |=> state == SP_IDLE)
    else $error("serial frame began without sync fall");

  sync_hold_a: assert property (ser_en && state == SP_SHIFT && !sclk_fall |=> state == SP_SHIFT)
    else $error("shift left early");

  load_len_a: assert property (load_pulse |-> $past(cnt) == DAC_CNT - 5'h01 && $past(state) == SP_SHIFT)
    else $error("load issued at wrong bit count");

  bcast_load_a: assert property (load_pulse && cmd.all
    |=> code_mem[0] == $past(cmd.code) && code_mem[CHAN_N-1] == $past(cmd.code))
    else $error("broadcast load missed a channel");

  rd_start_a: assert property (s_rd_start |=> state == SP_READ && cnt == '0 && !dout_oe)
    else $error("readback frame not started");

  oe_rise_a: assert property (ser_en && state == SP_READ && sclk_rise |=> dout_oe)
    else $error("data output not enabled on rise");

  oe_end_a: assert property (s_last_fall |=> !dout_oe && state == SP_IDLE && !rd_pend)
    else $error("data output not released after 14 clocks");

  msb_first_a: assert property (ser_en && state == SP_READ && sclk_rise |=> dout == $past(out_sh[CODE_W-1]))
    else $error("readback bit order wrong");

  din_quiet_a: assert property (state == SP_READ |=> $stable(shreg))
    else $error("input shifted during readback");

  par_acq_a: assert property (s_par_write |=> acq_pulse && cmd.all == $past(pin_f[PIN_CAL])
    && cmd.offset == $past(pin_f[PIN_OFS]))
    else $error("parallel write did not start acquisition");

  sequence s_hdr_done;
    ser_en && state == SP_SHIFT && sclk_fall && cnt == HDR_CNT - 5'h01;
  endsequence

  track_acq_a: assert property (s_hdr_done ##0 hdr_now.mode == MODE_TRACK |=> acq_pulse && !rd_pend)
    else $error("track frame did not start acquisition");

  rd_no_acq_a: assert property (s_hdr_done ##0 hdr_now.mode == MODE_RD |=> !acq_pulse && rd_pend)
    else $error("readback frame started acquisition");

  hdr_cmd_a: assert property (s_hdr_done ##0 hdr_now.mode != MODE_LOAD |=> cmd.chan == $past(hdr_now.chan))
    else $error("addressing field not decoded");

  code_idle_a: assert property (acq_pulse |-> cmd.code == '0)
    else $error("code field used outside load mode");

  acq_one_a: assert property (acq_pulse |=> !acq_pulse)
    else $error("acquisition pulse longer than one cycle");

  par_noload_a: assert property (!ser_en |=> !load_pulse)
    else $error("parallel port issued a load");

  par_ofs_a: assert property (!ser_en && wr_rise && !pin_f[PIN_SYNC] && pin_f[PIN_OFS]
    |=> cmd.offset && cmd.chan == '0)
    else $error("parallel offset select did not override address");

  bcast_ofs_a: assert property (load_pulse && cmd.all |=> code_mem[MEM_N-1] == $past(code_mem[MEM_N-1]))
    else $error("broadcast load touched the offset channel");

endmodule : dbp_port

/* dbp_host_model.sv */
module dbp_host_model (
  // clock and returned data
  input  wire logic clk_sys,
  input  wire logic dout,
  input  wire logic dout_oe,
  // link lines driven by the host
  output logic      sync_cs_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last;

  initial begin
    sync_cs_n = 1'b1;
    sclk      = 1'b0;
    din       = 1'b0;
    last      = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic cs(input logic lvl);
    sync_cs_n <= lvl;
    tick(6);
  endtask : cs

  task automatic run(input int n);
    repeat (n) begin
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
      tick(4);
    end
  endtask : run

  task automatic xfer(input int n, input logic [23:0] w, input bit glitch,
                      output logic [15:0] rd, output int oe_n);
    rd   = '0;
    oe_n = 0;
    cs(1'b0);
    for (int i = 0; i < n; i++) begin
      if (glitch && i == 5) begin
        cs(1'b1);
        cs(1'b0);
      end
      sclk <= 1'b1;
      din  <= w[23-i];
      tick(4);
      sclk <= 1'b0;
      tick(3);
      // read in the low phase; released line shows inverse
      last = dout_oe ? dout : ~last;
      rd   = {rd[14:0], last};
      oe_n = oe_n + int'(dout_oe);
      tick(1);
    end
    din <= ~w[24-n];
    cs(1'b1);
  endtask : xfer
endmodule : dbp_host_model

/* tb_dbp_port.sv */
module tb_dbp_port;
  import dbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [1:0]  m;
    logic        a;
    logic        o;
    logic [4:0]  ch;
    logic [13:0] code;
  } dbp_row_t;

  logic        clk_sys;
  logic        rst_n;
  logic        port_select_strap;
  logic        wr_n;
  logic [4:0]  channel_address;
  logic        offset_sel;
  logic        cal;
  logic        sync_cs_n, sclk, din, dout, dout_oe, acq_pulse, load_pulse;
  dbp_cmd_t    cmd;
  int          acq_n, load_n, error_cnt, samples_checked, cyc;
  logic [13:0] mem [MEM_N] = '{default: '0};
  dbp_row_t    rows [10] = '{
    '{2'h1, 1'b0, 1'b0, 5'h05, 14'h2A5C}, '{2'h1, 1'b0, 1'b0, 5'h1F, 14'h1234},
    '{2'h1, 1'b0, 1'b1, 5'h00, 14'h0F0F}, '{2'h3, 1'b0, 1'b0, 5'h05, 14'h0000},
    '{2'h3, 1'b0, 1'b1, 5'h00, 14'h0000}, '{2'h0, 1'b0, 1'b0, 5'h11, 14'h0000},
    '{2'h0, 1'b1, 1'b0, 5'h00, 14'h0000}, '{2'h1, 1'b1, 1'b0, 5'h00, 14'h3FFF},
    '{2'h2, 1'b0, 1'b0, 5'h1F, 14'h0000}, '{2'h3, 1'b0, 1'b0, 5'h00, 14'h0000}};

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  dbp_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .sync_cs_n(sync_cs_n),
    .port_select_strap(port_select_strap), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .wr_n(wr_n), .channel_address(channel_address),
    .offset_sel(offset_sel), .cal(cal), .acq_pulse(acq_pulse),
    .load_pulse(load_pulse), .cmd(cmd));

  dbp_host_model host (.clk_sys(clk_sys), .dout(dout), .dout_oe(dout_oe),
    .sync_cs_n(sync_cs_n), .sclk(sclk), .din(din));

  always @(posedge clk_sys) begin
    acq_n  <= acq_n + int'(acq_pulse === 1'b1);
    load_n <= load_n + int'(load_pulse === 1'b1);
    cyc    <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // one command frame, then an optional readback frame of nrd clocks
  task automatic frame(input dbp_row_t r, input int n, input bit g, input int nrd);
    int          a0, l0, idx, oe_n;
    logic [15:0] rd;
    a0  = acq_n;
    l0  = load_n;
    idx = r.o ? 32 : int'(r.ch);
    host.xfer(n, {r.m, r.a, r.o, r.ch, 1'b0, r.code}, g, rd, oe_n);
    chk(24'(acq_n - a0), 24'(port_select_strap && !r.m[0]), "acq count");
    chk(24'(load_n - l0), 24'(port_select_strap && r.m == 2'h1), "load count");
    if (port_select_strap && r.m != 2'h3)
      chk(24'(cmd[20:14]), 24'({r.a, r.o, r.ch}), "cmd addr");
    if (port_select_strap && r.m == 2'h1) begin
      chk(24'(cmd.code), 24'(r.code), "cmd code");
      for (int i = 0; i < MEM_N; i++)
        if (r.a ? i < CHAN_N : i == idx) mem[i] = r.code;
    end
    if (nrd > 0) begin
      if (r.m == 2'h2) host.tick(160);
      host.xfer(nrd, 24'hAAAAAA, 1'b0, rd, oe_n);
      chk(24'(nrd == 16 ? rd[15:2] : rd[13:0]), 24'(mem[idx]), "readback");
      chk(24'(oe_n), 24'h00000E, "drive span");
    end
  endtask : frame

  task automatic par(input logic [4:0] a, input logic o, input logic c, input logic csn,
                     input logic [6:0] exp);
    int a0;
    a0 = acq_n;
    channel_address <= a;
    offset_sel      <= o;
    cal             <= c;
    host.cs(csn);
    wr_n <= 1'b0;
    host.tick(6);
    wr_n <= 1'b1;
    host.tick(8);
    chk(24'(acq_n - a0), 24'(!csn), "par acq");
    if (!csn) chk(24'(cmd[20:14]), 24'(exp), "par cmd");
    host.cs(1'b1);
  endtask : par

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    rst_n             <= 1'b0;
    port_select_strap <= 1'b1;
    wr_n              <= 1'b1;
    channel_address   <= '0;
    offset_sel        <= 1'b0;
    cal               <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    host.tick(8);
    foreach (rows[i])
      frame(rows[i], rows[i].m == 2'h1 ? 24 : 10, 1'b0, rows[i].m[1] ? 14 : 0);
    frame('{2'h0, 1'b0, 1'b0, 5'h11, 14'h0000}, 16, 1'b0, 0);
    frame('{2'h3, 1'b0, 1'b0, 5'h05, 14'h0000}, 10, 1'b0, 16);
    frame('{2'h1, 1'b0, 1'b0, 5'h07, 14'h1C3A}, 24, 1'b1, 0);
    frame('{2'h3, 1'b0, 1'b0, 5'h07, 14'h0000}, 10, 1'b0, 14);
    host.run(3);
    frame('{2'h1, 1'b0, 1'b0, 5'h0A, 14'h2222}, 24, 1'b0, 0);
    host.run(3);
    frame('{2'h3, 1'b0, 1'b0, 5'h0A, 14'h0000}, 10, 1'b0, 14);
    port_select_strap <= 1'b0;
    host.tick(8);
    frame('{2'h1, 1'b0, 1'b0, 5'h09, 14'h0155}, 24, 1'b0, 0);
    par(5'h09, 1'b0, 1'b0, 1'b0, 7'h09);
    par(5'h09, 1'b1, 1'b0, 1'b0, 7'h20);
    par(5'h09, 1'b0, 1'b1, 1'b0, 7'h49);
    par(5'h09, 1'b0, 1'b0, 1'b1, 7'h00);
    rst_n <= 1'b0;
    host.tick(2);
    chk(24'(cmd), 24'h000000, "reset cmd");
    chk(24'(dout_oe), 24'h000000, "reset drive");
    rst_n             <= 1'b1;
    port_select_strap <= 1'b1;
    mem = '{default: '0};
    host.tick(8);
    frame('{2'h3, 1'b0, 1'b0, 5'h05, 14'h0000}, 10, 1'b0, 14);
    end_of_test();
  end
endmodule : tb_dbp_port
